/* rtl/pc_seq_defs.vh */
`ifndef PC_SEQ_DEFS_VH
`define PC_SEQ_DEFS_VH
// ----------------------------------------------------------------
// data space map
// ----------------------------------------------------------------
`define STACK_TOP_ADDR 16'hFDFF
`define SFR_BASE_ADDR 16'hFE00
`define MAIN_ARITH_ADDR 16'hFE00
`define SECOND_OPER_ADDR 16'hFE01
`define THIRD_OPER_ADDR 16'hFE02
`define INDIRECT_TOP_ADDR 16'h007F
`define OPER_RESET 8'h00
// ----------------------------------------------------------------
// program space
// ----------------------------------------------------------------
`define RESET_VEC_LOW 17'h00000
`define RESET_VEC_ALT 17'h01E00
`define IRQ_VEC_BASE 17'h00003
`define IRQ_SOURCES 10
`define OPTION_LO 17'h01F00
`define OPTION_HI 17'h01FFF
// ----------------------------------------------------------------
// sequencer commands
// ----------------------------------------------------------------
`define CMD_NONE 4'h0
`define CMD_SEQ 4'h1
`define CMD_BRANCH 4'h2
`define CMD_JUMP_ABS 4'h3
`define CMD_CALL_ABS 4'h4
`define CMD_JUMP_REL 4'h5
`define CMD_CALL_REL 4'h6
`define CMD_CALL_ARITH 4'h7
`define CMD_RETURN 4'h8
`define CMD_IRQ 4'h9
// ----------------------------------------------------------------
// operand register update kinds
// ----------------------------------------------------------------
`define OP_NONE 3'h0
`define OP_WR8 3'h1
`define OP_WR16 3'h2
`define OP_WR24 3'h3
`endif

/* rtl/ram9.v */
`timescale 1ns/100ps
`default_nettype none
// small 9-bit wide data memory, registered read
module ram9 #(
    parameter AW = 8
) (
    input wire clk_in,
    input wire we_in,
    input wire [AW-1:0] waddr_in,
    input wire [8:0] wdata_in,
    input wire [AW-1:0] raddr_in,
    output reg [8:0] rdata_out
);
    reg [8:0] mem [0:(1<<AW)-1];
    // ----------------------------------------------------------------
    // write and registered read
    // ----------------------------------------------------------------
    // no reset: contents are undefined until software writes them
    always @(posedge clk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
        rdata_out <= mem[raddr_in];
    end
endmodule
`default_nettype wire

/* rtl/pc_sequencer.v */
`timescale 1ns/100ps
`default_nettype none
`include "pc_seq_defs.vh"
module pc_sequencer #(
    parameter RAM_AW = 8
) (
    input wire mclk_in,
    input wire nrst_in,
    input wire alt_start_in,
    input wire [3:0] cmd_in,
    input wire [2:0] inst_len_in,
    input wire [7:0] disp8_in,
    input wire [11:0] disp12_in,
    input wire [16:0] target_in,
    input wire [3:0] irq_src_in,
    input wire [15:0] ram_addr_in,
    input wire ram_we_in,
    input wire [7:0] ram_wdata_in,
    input wire ram_bit8_in,
    input wire [2:0] op_kind_in,
    input wire [23:0] op_result_in,
    input wire [5:0] ind_sel_in,
    input wire [15:0] ind_value_in,
    input wire ind_bit8_in,
    input wire lookup_bank_in,
    input wire [15:0] ext_low_in,
    output reg [16:0] pc_out,
    output reg rom_bank_flag_out,
    output reg [17:0] fetch_addr_out,
    output reg [15:0] stack_pointer_out,
    output reg [7:0] main_arith_reg_out,
    output reg [7:0] second_oper_out,
    output reg [7:0] third_oper_out,
    output reg [7:0] ram_rdata_out,
    output reg ram_bit8_out,
    output reg [17:0] lookup_addr_out,
    output reg [15:0] offset_addr_out,
    output reg [23:0] ext_addr_out,
    output reg option_area_out,
    output reg busy_out
);
    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    reg rst_meta;
    reg rst_sync;
    wire rst_n;
    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end
    assign rst_n = rst_sync;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // 17-bit wrap keeps the bank flag out of the carry
    function [16:0] pc_add;
        input [16:0] base;
        input [16:0] delta;
        begin
            pc_add = base + delta;
        end
    endfunction

    function is_sfr;
        input [15:0] a;
        begin
            is_sfr = (a >= `SFR_BASE_ADDR);
        end
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    localparam ST_RUN = 2'h0;
    localparam ST_PUSH_HI = 2'h1;
    localparam ST_POP_LO = 2'h2;
    localparam ST_POP_DONE = 2'h3;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [16:0] next_pc;
    reg next_bank;
    reg [15:0] next_sp;
    reg [16:0] ret_pc; // address saved by a call or interrupt
    reg [16:0] next_ret_pc;
    reg [8:0] pop_hi;
    reg [8:0] next_pop_hi;
    reg start_seen;
    reg seq_we;
    reg [15:0] seq_addr;
    reg [8:0] seq_wdata;
    reg seq_rd;

    wire [16:0] len17 = {14'h0000, inst_len_in};
    wire [16:0] d8 = {{9{disp8_in[7]}}, disp8_in};
    wire [16:0] d12 = {{5{disp12_in[11]}}, disp12_in};
    wire [16:0] vec = `IRQ_VEC_BASE + {10'h000, irq_src_in, 3'h0};
    wire [16:0] next_seq = pc_add(pc_out, len17);
    wire [8:0] ram_rd;

    // ----------------------------------------------------------------
    // program counter sequencing
    // ----------------------------------------------------------------
    // calls need a second cycle to push the high part; busy stalls the core
    always @* begin
        next_state = ST_RUN;
        next_pc = pc_out;
        next_bank = rom_bank_flag_out;
        next_sp = stack_pointer_out;
        next_ret_pc = ret_pc;
        next_pop_hi = pop_hi;
        seq_we = 1'b0;
        seq_addr = stack_pointer_out;
        seq_wdata = 9'h000;
        seq_rd = 1'b0;
        case (state)
            ST_RUN: begin
                case (cmd_in)
                    `CMD_SEQ: begin
                        next_pc = next_seq;
                    end
                    `CMD_BRANCH: begin
                        next_pc = pc_add(next_seq, d8);
                    end
                    `CMD_JUMP_ABS: begin
                        next_pc = target_in;
                    end
                    `CMD_JUMP_REL: begin
                        next_pc = pc_add(pc_add(pc_out, 17'h00002), d12);
                    end
                    `CMD_CALL_ABS, `CMD_CALL_REL, `CMD_CALL_ARITH: begin
                        next_ret_pc = next_seq;
                        if (cmd_in == `CMD_CALL_ABS) begin
                            next_pc = target_in;
                        end else if (cmd_in == `CMD_CALL_REL) begin
                            next_pc = pc_add(pc_add(pc_out, 17'h00002), d12);
                        end else begin
                            next_pc = pc_add(pc_add(pc_out, 17'h00001),
                                {9'h000, main_arith_reg_out});
                        end
                        seq_we = 1'b1;
                        seq_addr = stack_pointer_out + 16'h0001;
                        seq_wdata = {rom_bank_flag_out, next_seq[7:0]};
                        next_state = ST_PUSH_HI;
                    end
                    `CMD_IRQ: begin
                        if ({1'b0, irq_src_in} < `IRQ_SOURCES) begin
                            next_ret_pc = pc_out;
                            next_pc = vec;
                            next_bank = 1'b0;
                            seq_we = 1'b1;
                            seq_addr = stack_pointer_out + 16'h0001;
                            seq_wdata = {rom_bank_flag_out, pc_out[7:0]};
                            next_state = ST_PUSH_HI;
                        end
                    end
                    `CMD_RETURN: begin
                        // only path that may set the bank; an interrupt can only clear it
                        seq_rd = 1'b1;
                        seq_addr = stack_pointer_out;
                        next_sp = stack_pointer_out - 16'h0001;
                        next_state = ST_POP_LO;
                    end
                    default: begin
                        next_state = ST_RUN;
                    end
                endcase
            end
            ST_PUSH_HI: begin
                seq_we = 1'b1;
                seq_addr = stack_pointer_out + 16'h0002;
                seq_wdata = ret_pc[16:8];
                next_sp = stack_pointer_out + 16'h0002;
            end
            ST_POP_LO: begin
                next_pop_hi = ram_rd; // high 9 bits from SP
                seq_rd = 1'b1;
                seq_addr = stack_pointer_out;
                next_sp = stack_pointer_out - 16'h0001;
                next_state = ST_POP_DONE;
            end
            ST_POP_DONE: begin
                next_pc = {pop_hi, ram_rd[7:0]};
                next_bank = ram_rd[8];
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    // strap sampled once after reset release, never under reset itself
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_RUN;
            pc_out <= `RESET_VEC_LOW;
            rom_bank_flag_out <= 1'b0;
            stack_pointer_out <= 16'h0000;
            ret_pc <= 17'h00000;
            pop_hi <= 9'h000;
            start_seen <= 1'b0;
            busy_out <= 1'b1;
        end else if (!start_seen) begin
            start_seen <= 1'b1;
            pc_out <= alt_start_in ? `RESET_VEC_ALT : `RESET_VEC_LOW;
            rom_bank_flag_out <= 1'b0;
            busy_out <= 1'b0;
        end else begin
            state <= next_state;
            pc_out <= next_pc;
            rom_bank_flag_out <= next_bank;
            stack_pointer_out <= next_sp;
            ret_pc <= next_ret_pc;
            pop_hi <= next_pop_hi;
            busy_out <= (next_state != ST_RUN);
        end
    end

    // ----------------------------------------------------------------
    // fetch address and option area
    // ----------------------------------------------------------------
    // start cycle loads the strap address, so fetch must follow it too
    wire [16:0] load_pc = start_seen ? next_pc : (alt_start_in ? `RESET_VEC_ALT : `RESET_VEC_LOW);
    wire load_bank = start_seen && next_bank;
    // 18-bit byte address spans the 256K program space
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            fetch_addr_out <= 18'h00000;
            option_area_out <= 1'b0;
        end else begin
            fetch_addr_out <= {load_bank, load_pc};
            option_area_out <= !load_bank && (load_pc >= `OPTION_LO)
                && (load_pc <= `OPTION_HI);
        end
    end

    // ----------------------------------------------------------------
    // data RAM access
    // ----------------------------------------------------------------
    // sequencer owns the port on its stack reads and writes; core writes are ignored while busy
    wire core_ram_we = ram_we_in && (state == ST_RUN) && (cmd_in == `CMD_NONE)
        && !is_sfr(ram_addr_in) && (ram_addr_in <= `STACK_TOP_ADDR);
    wire [15:0] ram_a_full = (seq_we || seq_rd) ? seq_addr : ram_addr_in;
    wire [RAM_AW-1:0] ram_a = ram_a_full[RAM_AW-1:0];

    ram9 #(
        .AW(RAM_AW)
    ) u_ram (
        .clk_in(mclk_in),
        .we_in(seq_we || core_ram_we),
        .waddr_in(ram_a),
        .wdata_in(seq_we ? seq_wdata : {ram_bit8_in, ram_wdata_in}),
        .raddr_in(ram_a),
        .rdata_out(ram_rd)
    );

    // ----------------------------------------------------------------
    // operand registers
    // ----------------------------------------------------------------
    wire sfr_we = ram_we_in && (state == ST_RUN);
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            main_arith_reg_out <= `OPER_RESET;
            second_oper_out <= `OPER_RESET;
            third_oper_out <= `OPER_RESET;
        end else begin
            case (op_kind_in)
                `OP_WR8: begin
                    main_arith_reg_out <= op_result_in[7:0];
                end
                `OP_WR16: begin
                    {second_oper_out, main_arith_reg_out} <= op_result_in[15:0];
                end
                `OP_WR24: begin
                    {third_oper_out, second_oper_out, main_arith_reg_out} <=
                        op_result_in;
                end
                default: begin
                    if (sfr_we && ram_addr_in == `MAIN_ARITH_ADDR) begin
                        main_arith_reg_out <= ram_wdata_in;
                    end
                    if (sfr_we && ram_addr_in == `SECOND_OPER_ADDR) begin
                        second_oper_out <= ram_wdata_in;
                    end
                    if (sfr_we && ram_addr_in == `THIRD_OPER_ADDR) begin
                        third_oper_out <= ram_wdata_in;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // read data, derived addresses
    // ----------------------------------------------------------------
    // SFR reads at FE00..FE02 return the operand registers with the ninth bit zero; other SFR addresses read RAM
    reg [15:0] rd_addr_q;
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            rd_addr_q <= 16'h0000;
            lookup_addr_out <= 18'h00000;
            offset_addr_out <= 16'h0000;
            ext_addr_out <= 24'h000000;
        end else begin
            rd_addr_q <= ram_addr_in;
            // indirect register sits at RAM pair 2n, 2n+1
            lookup_addr_out <= {lookup_bank_in, ind_bit8_in, ind_value_in};
            offset_addr_out <= ind_value_in
                + {{8{third_oper_out[7]}}, third_oper_out};
            ext_addr_out <= {second_oper_out, ext_low_in};
        end
    end
    // ind_sel_in names R0..R63 at byte 2n; RAM below 0080H holds them
    wire [15:0] ind_byte_addr = {9'h000, ind_sel_in, 1'b0};
    wire ind_ok = (ind_byte_addr < `INDIRECT_TOP_ADDR);

    // extra register keeps read data a clean flop output, at one more cycle
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            ram_rdata_out <= 8'h00;
            ram_bit8_out <= 1'b0;
        end else begin
            case (rd_addr_q)
                `MAIN_ARITH_ADDR: begin
                    ram_rdata_out <= main_arith_reg_out;
                    ram_bit8_out <= 1'b0;
                end
                `SECOND_OPER_ADDR: begin
                    ram_rdata_out <= second_oper_out;
                    ram_bit8_out <= 1'b0;
                end
                `THIRD_OPER_ADDR: begin
                    ram_rdata_out <= third_oper_out;
                    ram_bit8_out <= 1'b0;
                end
                default: begin
                    ram_rdata_out <= ram_rd[7:0];
                    ram_bit8_out <= ram_rd[8] && ind_ok;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* bench/pc_sequencer_properties.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// sequencer port properties
// ----------------------------------------
module pc_seq_props (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic [3:0] cmd_in,
    input wire logic [2:0] inst_len_in,
    input wire logic [7:0] disp8_in,
    input wire logic [11:0] disp12_in,
    input wire logic [16:0] target_in,
    input wire logic [3:0] irq_src_in,
    input wire logic [16:0] pc_out,
    input wire logic rom_bank_flag_out,
    input wire logic [15:0] stack_pointer_out,
    input wire logic [7:0] main_arith_reg_out,
    input wire logic busy_out
);
    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (!nrst_in);
    // accepted command, push kinds and sign-extended displacements
    wire logic go = !busy_out && cmd_in != 4'h0;
    wire logic irq_ok = cmd_in == 4'h9 && irq_src_in < 4'hA;
    wire logic push = go && (cmd_in == 4'h4 || cmd_in == 4'h6 || cmd_in == 4'h7 || irq_ok);
    wire logic [16:0] s8 = {{9{disp8_in[7]}}, disp8_in};
    wire logic [16:0] s12 = {{5{disp12_in[11]}}, disp12_in};
    // busy windows of the two-word push and pop
    sequence push_busy;
        busy_out ##1 !busy_out;
    endsequence
    sequence pop_busy;
        busy_out [*2] ##1 !busy_out;
    endsequence
    seq_step_a: assert property (
        go && cmd_in == 4'h1 |=> pc_out == $past(pc_out) + $past(inst_len_in)
    ) else $error("sequential step wrong");
    branch_sum_a: assert property (
        go && cmd_in == 4'h2 |=> pc_out == $past(pc_out) + $past(inst_len_in) + $past(s8)
    ) else $error("branch target wrong");
    abs_load_a: assert property (
        go && (cmd_in == 4'h3 || cmd_in == 4'h4) |=> pc_out == $past(target_in)
    ) else $error("absolute target wrong");
    rel_load_a: assert property (
        go && (cmd_in == 4'h5 || cmd_in == 4'h6) |=> pc_out == $past(pc_out) + 17'h2 + $past(s12)
    ) else $error("relative target wrong");
    arith_call_a: assert property (
        go && cmd_in == 4'h7 |=> pc_out == $past(pc_out) + 17'h1 + $past(main_arith_reg_out)
    ) else $error("arith call target wrong");
    irq_vector_a: assert property (
        go && irq_ok |=> pc_out == {10'h000, $past(irq_src_in), 3'h3} && !rom_bank_flag_out
    ) else $error("vector load wrong");
    bank_hold_a: assert property (
        go && cmd_in < 4'h8 |=> rom_bank_flag_out == $past(rom_bank_flag_out)
    ) else $error("bank flag moved");
    push_sp_a: assert property (
        push |=> push_busy ##0 stack_pointer_out == $past(stack_pointer_out, 2) + 16'h2
    ) else $error("push stack pointer wrong");
    pop_sp_a: assert property (
        go && cmd_in == 4'h8 |=> pop_busy ##0 stack_pointer_out == $past(stack_pointer_out, 3) - 16'h2
    ) else $error("pop stack pointer wrong");
endmodule
`default_nettype wire

/* bench/rom_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// program rom stand-in
// ----------------------------------------
module rom_model (
    input wire logic [17:0] fetch_addr_in,
    output logic [2:0] inst_len_out,
    output logic [7:0] disp8_out
);
    // opcode fields decoded from the full {bank, pc} byte address
    always_comb begin
        inst_len_out = {1'b0, fetch_addr_in[1:0]} + 3'h1;
        disp8_out = fetch_addr_in[9:2] ^ {fetch_addr_in[17], 7'h25};
        // option bytes hold no code, so step one byte at a time there
        if (!fetch_addr_in[17] && fetch_addr_in[16:8] == 9'h01F) inst_len_out = 3'h1;
    end
endmodule
`default_nettype wire

/* bench/tb_cpu_pc_sequencer_core_regs.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// stimulus, expectations and report
// ----------------------------------------
module tb_cpu_pc_sequencer_core_regs;
    logic mclk_in = 1'b0, nrst_in = 1'b0, alt_start_in = 1'b1, ram_we_in = 1'b0;
    logic ram_bit8_in = 1'b0, ind_bit8_in = 1'b0, lookup_bank_in = 1'b0;
    logic [3:0] cmd_in = 4'h0, irq_src_in = 4'h0, c;
    logic [2:0] inst_len_in = 3'h1, op_kind_in = 3'h0;
    logic [7:0] disp8_in = 8'h00, ram_wdata_in = 8'h00, ea, eb, ec;
    logic [11:0] disp12_in = 12'h000;
    logic [16:0] target_in = 17'h00000, epc;
    logic [15:0] ram_addr_in = 16'h0000, ind_value_in = 16'h0000, ext_low_in = 16'h0000;
    logic [15:0] esp, a;
    logic [23:0] op_result_in = 24'h000000;
    logic [5:0] ind_sel_in = 6'h00;
    logic [8:0] d;
    logic ebank;
    logic [16:0] q_pc[$];
    logic q_bank[$];
    logic [16:0] bnd[5] = '{17'h01EFF, 17'h01F00, 17'h01FFF, 17'h02000, 17'h1FFFE};
    wire logic [16:0] pc_out;
    wire logic [17:0] fetch_addr_out, lookup_addr_out;
    wire logic [15:0] stack_pointer_out, offset_addr_out;
    wire logic [7:0] main_arith_reg_out, second_oper_out, third_oper_out, ram_rdata_out;
    wire logic [23:0] ext_addr_out;
    wire logic rom_bank_flag_out, ram_bit8_out, option_area_out, busy_out;
    wire logic [2:0] rom_len;
    wire logic [7:0] rom_disp;
    integer seed = 32'h14FF0E2D;
    integer miscompares = 0;
    integer comparisons = 0;
    integer cycles = 0;
    integer k;

    pc_sequencer #(.RAM_AW(8)) uut (
        .mclk_in, .nrst_in, .alt_start_in, .cmd_in, .inst_len_in, .disp8_in, .disp12_in,
        .target_in, .irq_src_in, .ram_addr_in, .ram_we_in, .ram_wdata_in, .ram_bit8_in,
        .op_kind_in, .op_result_in, .ind_sel_in, .ind_value_in, .ind_bit8_in,
        .lookup_bank_in, .ext_low_in, .pc_out, .rom_bank_flag_out, .fetch_addr_out,
        .stack_pointer_out, .main_arith_reg_out, .second_oper_out, .third_oper_out,
        .ram_rdata_out, .ram_bit8_out, .lookup_addr_out, .offset_addr_out, .ext_addr_out,
        .option_area_out, .busy_out
    );
    rom_model rom (.fetch_addr_in(fetch_addr_out), .inst_len_out(rom_len), .disp8_out(rom_disp));

    // 10 MHz clock
    initial begin
        forever #50 mclk_in = ~mclk_in;
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            test_done;
        end
    end
    // inputs always move 10 ns after the rising edge
    task tick;
        @(posedge mclk_in);
        #10;
    endtask
    task automatic wait_idle;
        integer n = 0;
        while (busy_out !== 1'b0 && n < 8) begin
            tick;
            n++;
        end
    endtask
    task automatic chk_dat(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_pc(input logic [17:0] got, input logic [17:0] exp);
        chk_dat({6'h00, got}, {6'h00, exp});
    endtask
    task test_done;
        if (miscompares == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic do_reset(input logic alt);
        alt_start_in = alt;
        nrst_in = 1'b0;
        repeat (16) tick;
        nrst_in = 1'b1;
        tick;
        wait_idle;
        epc = alt ? 17'h01E00 : 17'h00000;
        ebank = 1'b0;
        esp = 16'h0000;
        {ec, eb, ea} = 24'h000000;
        q_pc.delete();
        q_bank.delete();
        chk_pc({rom_bank_flag_out, pc_out}, {ebank, epc});
        chk_dat({third_oper_out, second_oper_out, main_arith_reg_out}, 24'h0);
        chk_dat(stack_pointer_out, esp);
    endtask
    // one command; the model keeps pc, bank, stack pointer and pushed words
    task automatic issue(input logic [3:0] cc);
        logic irq;
        logic [16:0] ret;
        inst_len_in = rom_len;
        disp8_in = rom_disp;
        irq = cc == 4'h9 && irq_src_in < 4'hA;
        ret = irq ? epc : epc + inst_len_in;
        if (cc == 4'h4 || cc == 4'h6 || cc == 4'h7 || irq) begin
            q_pc.push_back(ret);
            q_bank.push_back(ebank);
            esp = esp + 16'h2;
        end
        case (cc)
            4'h1: epc = epc + inst_len_in;
            4'h2: epc = epc + inst_len_in + {{9{disp8_in[7]}}, disp8_in};
            4'h3, 4'h4: epc = target_in;
            4'h5, 4'h6: epc = epc + 17'h2 + {{5{disp12_in[11]}}, disp12_in};
            4'h7: epc = epc + 17'h1 + ea;
            4'h8: begin
                epc = q_pc.pop_back();
                ebank = q_bank.pop_back();
                esp = esp - 16'h2;
            end
            default: begin
                if (irq) epc = {10'h000, irq_src_in, 3'h3};
                if (irq) ebank = 1'b0;
            end
        endcase
        cmd_in = cc;
        tick;
        cmd_in = 4'h0;
        tick;
        wait_idle;
        chk_pc({rom_bank_flag_out, pc_out}, {ebank, epc});
        chk_pc(fetch_addr_out, {ebank, epc});
        chk_dat(stack_pointer_out, esp);
        chk_dat(option_area_out, !ebank && epc >= 17'h01F00 && epc <= 17'h01FFF);
    endtask
    task automatic ram_wr(input logic [15:0] ad, input logic [8:0] dt);
        ram_addr_in = ad;
        {ram_bit8_in, ram_wdata_in} = dt;
        ram_we_in = 1'b1;
        tick;
        ram_we_in = 1'b0;
        tick;
    endtask
    // read data stands two edges after the address
    task automatic ram_rd(input logic [15:0] ad, input logic [8:0] exp);
        ram_addr_in = ad;
        tick;
        tick;
        chk_dat({ram_bit8_out, ram_rdata_out}, exp);
    endtask
    task automatic op_wr(input logic [2:0] kind, input logic [23:0] r);
        op_kind_in = kind;
        op_result_in = r;
        tick;
        op_kind_in = 3'h0;
        ea = r[7:0];
        if (kind > 3'h1) eb = r[15:8];
        if (kind > 3'h2) ec = r[23:16];
    endtask

    // main sequence: corners first, then random traffic, then data side
    initial begin
        do_reset(1'b1);
        foreach (bnd[i]) begin
            target_in = bnd[i];
            issue(4'h3);
        end
        issue(4'h1);
        for (k = 0; k < 12; k++) begin
            irq_src_in = k[3:0];
            issue(4'h9);
        end
        for (k = 0; k < 80; k++) begin
            c = 4'(1 + {$random(seed)} % 9);
            if (c == 4'h8 && q_pc.size() == 0) c = 4'h1;
            if (q_pc.size() > 50) c = 4'h8;
            if (c == 4'h7) op_wr(3'h1, 24'($random(seed)));
            disp12_in = 12'($random(seed));
            target_in = 17'($random(seed));
            irq_src_in = 4'({$random(seed)} % 12);
            issue(c);
        end
        while (q_pc.size() > 0) issue(4'h8);
        target_in = 17'h1ABCD;
        issue(4'h4);
        ram_rd(esp - 16'h1, {q_bank[$], q_pc[$][7:0]});
        ram_rd(esp, q_pc[$][16:8]);
        ram_wr(esp - 16'h1, 9'h134);
        ram_wr(esp, 9'h0AB);
        q_pc[$] = 17'h0AB34;
        q_bank[$] = 1'b1;
        issue(4'h8);
        issue(4'h2);
        irq_src_in = 4'h0;
        issue(4'h9);
        issue(4'h8);
        repeat (6) begin
            a = 16'h0090 + 16'({$random(seed)} % 112);
            d = 9'($random(seed));
            ram_wr(a, d);
            ram_rd(a, d);
        end
        ram_wr(16'hFE01, 9'h05A);
        ram_wr(16'hFE03, 9'h0FF);
        eb = 8'h5A;
        chk_dat({third_oper_out, second_oper_out, main_arith_reg_out}, {ec, eb, ea});
        ram_rd(16'hFE01, {1'b0, eb});
        ram_rd(16'hFE00, {1'b0, ea});
        for (k = 0; k < 9; k++) begin
            op_wr(3'(1 + k % 3), 24'($random(seed)));
            ind_value_in = 16'($random(seed));
            ind_bit8_in = k[0];
            lookup_bank_in = k[1];
            ind_sel_in = 6'(k);
            ext_low_in = 16'($random(seed));
            tick;
            tick;
            chk_dat({third_oper_out, second_oper_out, main_arith_reg_out}, {ec, eb, ea});
            chk_dat(lookup_addr_out, {lookup_bank_in, ind_bit8_in, ind_value_in});
            chk_dat(offset_addr_out, 16'(ind_value_in + {{8{ec[7]}}, ec}));
            chk_dat(ext_addr_out, {eb, ext_low_in});
        end
        do_reset(1'b0);
        issue(4'h1);
        test_done;
    end
endmodule
bind pc_sequencer pc_seq_props chk (
    .mclk_in, .nrst_in, .cmd_in, .inst_len_in, .disp8_in, .disp12_in, .target_in,
    .irq_src_in, .pc_out, .rom_bank_flag_out, .stack_pointer_out, .main_arith_reg_out,
    .busy_out
);
`default_nettype wire
